// ===== verilog/srm_pkg.sv
// srm_pkg: constants and command encoding for the sdram row/column address mux.
// assumes one 50 MHz clock and a synchronous active-high reset in every user.
package srm_pkg;

  // logical sdram address lines a0..a19 and byte address width
  localparam int SRM_ADDR_W = 20;
  localparam int SRM_BYTE_ADDR_W = 29;

  // column count is 8 plus the column code (0:8, 1:9, 2:10)
  localparam logic [4:0] SRM_COL_BASE = 5'h08;
  // highest row+bank line count that may be configured (a0..a15)
  localparam logic [4:0] SRM_ROW_BANK_MAX = 5'h10;

  // field positions inside the logical address word
  localparam int SRM_PRECHG_BIT = 10; // auto-precharge line, low on column commands
  localparam int SRM_BANK_LO = 11; // bank/high row lines repeated in column cycles
  localparam int SRM_BANK_HI = 15;
  localparam int SRM_XFER_BIT = 16; // transfer-type flag during activate
  localparam int SRM_COL_HI = 9; // top line that can carry a column bit

  // values after reset
  localparam logic [19:0] SRM_ADDR_RST = 20'h00000;
  localparam logic [4:0] SRM_BANK_RST = 5'h00;
  localparam logic SRM_XFER_RST = 1'b1;

  // command code presented by the sequencer
  typedef enum logic [1:0] {
    SRM_CMD_IDLE = 2'b00,
    SRM_CMD_ACT = 2'b01,
    SRM_CMD_RD = 2'b10,
    SRM_CMD_WR = 2'b11
  } srm_cmd_t;

endpackage

// ===== verilog/srm_addr_map.sv
// srm_addr_map: combinational split of a byte address into row and column words.
// assumes the caller registers the results before they reach any pin.
`timescale 1ns/1ps
module srm_addr_map
  import srm_pkg::*;
#(
  parameter int ADDR_W = SRM_ADDR_W,
  parameter int BYTE_W = SRM_BYTE_ADDR_W
) (
  input wire logic [BYTE_W-1:0] byte_addr,
  input wire logic [1:0] col_cfg,
  input wire logic [1:0] width_cfg,
  input wire logic [4:0] row_bank_bits,
  output logic [ADDR_W-1:0] row_word,
  output logic [ADDR_W-1:0] col_word
);

  //////////////////////////////////////////////////////////////////////////////
  // shift amounts
  // byte-lane bits drop off first, then the column bits for the row word
  wire [4:0] col_n = SRM_COL_BASE + {3'h0, col_cfg};
  wire [4:0] row_shift = col_n + {3'h0, width_cfg};
  wire [BYTE_W-1:0] row_raw = byte_addr >> row_shift;
  wire [BYTE_W-1:0] col_raw = byte_addr >> width_cfg;

  //////////////////////////////////////////////////////////////////////////////
  // per-line selection
  // lines past the configured geometry stay low so unused pins do not toggle
  genvar k;
  generate
    for (k = 0; k < ADDR_W; k = k + 1) begin : g_line
      wire row_used = (k <= SRM_BANK_HI) && (5'(k) < row_bank_bits);
      wire col_used = (k <= SRM_COL_HI) && (5'(k) < col_n);
      assign row_word[k] = row_used & row_raw[k];
      assign col_word[k] = col_used & col_raw[k];
    end
  endgenerate

endmodule // srm_addr_map

// ===== verilog/srm_addr_mux.sv
// srm_addr_mux: drives the logical sdram address lines for activate and column cycles.
// assumes a sequencer that issues one command per cycle and keeps config static
// while rows are open.
`timescale 1ns/1ps
module srm_addr_mux
  import srm_pkg::*;
#(
  parameter int ADDR_W = SRM_ADDR_W,
  parameter int BYTE_W = SRM_BYTE_ADDR_W
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [1:0] cmd, // srm_cmd_t code, idle when nothing is issued
  input wire logic [BYTE_W-1:0] byte_addr, // byte address of the access
  input wire logic xfer_normal, // 1 ordinary access, 0 peripheral direct transfer
  input wire logic [1:0] col_cfg, // column bits: 0=8, 1=9, 2=10
  input wire logic [1:0] width_cfg, // bus width: 0=8, 1=16, 2=32, 3=64
  input wire logic [4:0] row_bank_bits, // row plus bank lines in use, up to 16
  output logic [ADDR_W-1:0] ext_addr_pin, // logical lines a0..a19
  output logic row_activate_cmd, // this cycle's word is an activate
  output logic column_write_cmd, // this cycle's word is a write column
  output logic column_read_cmd // this cycle's word is a read column
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [ADDR_W-1:0] addr_ff; // registered pin word
  logic act_ff; // activate strobe
  logic wr_ff; // write column strobe
  logic rd_ff; // read column strobe
  logic [SRM_BANK_HI:SRM_BANK_LO] bank_ff; // bank lines caught at activate
  logic xfer_ff; // flag caught at activate
  logic [ADDR_W-1:0] row_word; // mapped row word
  logic [ADDR_W-1:0] col_word; // mapped column word

  //////////////////////////////////////////////////////////////////////////////
  // address mapping
  srm_addr_map #(
    .ADDR_W(ADDR_W),
    .BYTE_W(BYTE_W)
  ) u_map (
    .byte_addr(byte_addr),
    .col_cfg(col_cfg),
    .width_cfg(width_cfg),
    .row_bank_bits(row_bank_bits),
    .row_word(row_word),
    .col_word(col_word)
  );

  //////////////////////////////////////////////////////////////////////////////
  // command decode and word selection
  wire is_act = (cmd == SRM_CMD_ACT);
  wire is_rd = (cmd == SRM_CMD_RD);
  wire is_wr = (cmd == SRM_CMD_WR);
  wire is_col = is_rd | is_wr;

  // activate word: row/bank lines plus the transfer flag, a17..a19 low
  wire [ADDR_W-1:0] act_word = row_word | ({{(ADDR_W-1){1'b0}}, xfer_normal} << SRM_XFER_BIT);

  // column word: the bank lines must match what the memory latched at activate,
  // so they come from the copy kept then, not from today's address
  wire [ADDR_W-1:0] bank_word = {{(ADDR_W-SRM_BANK_HI-1){1'b0}}, bank_ff, {SRM_BANK_LO{1'b0}}};
  wire [ADDR_W-1:0] flag_word = {{(ADDR_W-1){1'b0}}, xfer_ff} << SRM_XFER_BIT;
  // col_word never reaches the precharge line, so it reads low here
  wire [ADDR_W-1:0] cas_word = col_word | bank_word | flag_word;

  // idle keeps the last word so the pins do not glitch between commands
  wire [ADDR_W-1:0] nxt_addr = is_act ? act_word : (is_col ? cas_word : addr_ff);

  //////////////////////////////////////////////////////////////////////////////
  // pin register
  always_ff @(posedge clk) begin
    if (srst) begin
      addr_ff <= SRM_ADDR_RST;
      act_ff <= 1'b0;
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
    end else begin
      addr_ff <= nxt_addr;
      act_ff <= is_act;
      wr_ff <= is_wr;
      rd_ff <= is_rd;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // bank and flag capture at activate
  always_ff @(posedge clk) begin
    if (srst) begin
      bank_ff <= SRM_BANK_RST;
      xfer_ff <= SRM_XFER_RST;
    end else if (is_act) begin
      bank_ff <= row_word[SRM_BANK_HI:SRM_BANK_LO];
      xfer_ff <= xfer_normal;
    end
  end

  assign ext_addr_pin = addr_ff;
  assign row_activate_cmd = act_ff;
  assign column_write_cmd = wr_ff;
  assign column_read_cmd = rd_ff;

  //////////////////////////////////////////////////////////////////////////////
  // checking helpers: reference values computed independently of the mapper
  logic [4:0] chk_rshift;
  logic [4:0] chk_cols;
  logic [15:0] chk_rmask;
  logic [9:0] chk_cmask;
  logic [BYTE_W-1:0] chk_row;
  logic [BYTE_W-1:0] chk_col;
  // lines a0..a16 shown at the last activate; the flag bit starts at its reset value
  // so a column issued before any activate is still judged
  logic [16:0] chk_act_lines;
  always_comb begin
    chk_cols = 5'd8 + {3'd0, col_cfg};
    chk_rshift = chk_cols + {3'd0, width_cfg};
    chk_rmask = 16'(({17'd0} | 17'h1_0000 >> (5'd16 - row_bank_bits)) - 17'd1);
    chk_cmask = 10'((11'd1 << chk_cols) - 11'd1);
    chk_row = byte_addr >> chk_rshift;
    chk_col = byte_addr >> width_cfg;
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      chk_act_lines <= {SRM_XFER_RST, 16'h0000};
    end else if (act_ff) begin
      chk_act_lines <= addr_ff[16:0];
    end
  end

  a_row_map: assert property (@(posedge clk) disable iff (srst)
    is_act && row_bank_bits <= SRM_ROW_BANK_MAX |=> addr_ff[15:0] == $past(chk_row[15:0] & chk_rmask))
    else $error("row word does not match byte address");
  a_col_map: assert property (@(posedge clk) disable iff (srst)
    is_col |=> addr_ff[9:0] == $past(chk_col[9:0] & chk_cmask))
    else $error("column word does not match byte address");
  a_bank_repeat: assert property (@(posedge clk) disable iff (srst)
    (rd_ff || wr_ff) |-> addr_ff[15:11] == chk_act_lines[15:11])
    else $error("bank lines differ from the activate cycle");
  a_prechg_low: assert property (@(posedge clk) disable iff (srst)
    is_col ##1 1'b1 |-> !addr_ff[SRM_PRECHG_BIT] && (rd_ff || wr_ff))
    else $error("precharge line high on column command");
  a_xfer_flag: assert property (@(posedge clk) disable iff (srst)
    is_act |=> act_ff && addr_ff[SRM_XFER_BIT] == $past(xfer_normal))
    else $error("transfer flag wrong at activate");
  a_high_low: assert property (@(posedge clk) disable iff (srst)
    is_act |=> addr_ff[19:17] == 3'h0 && (addr_ff[15:0] & ~$past(chk_rmask)) == 16'h0000)
    else $error("unused address lines not low");
  // column cycles: nothing above the flag line may toggle either
  a_col_high_low: assert property (@(posedge clk) disable iff (srst)
    (rd_ff || wr_ff) |-> addr_ff[19:17] == 3'h0)
    else $error("unused address lines not low on column command");
  // judged on the strobe itself, so a column word reached by any path is covered
  a_prechg_strobe: assert property (@(posedge clk) disable iff (srst)
    (rd_ff || wr_ff) |-> !addr_ff[SRM_PRECHG_BIT])
    else $error("precharge line high while a column strobe stands");
  // the memory decodes one command per edge, so two strobes at once are fatal to it
  a_strobe_onehot: assert property (@(posedge clk) disable iff (srst)
    $onehot0({act_ff, wr_ff, rd_ff}))
    else $error("more than one command strobe high");
  // an idle cycle keeps the pins still and lets every strobe drop after one cycle
  a_idle_hold: assert property (@(posedge clk) disable iff (srst)
    cmd == SRM_CMD_IDLE |=> $stable(addr_ff) && !act_ff && !wr_ff && !rd_ff)
    else $error("pins changed or a strobe rose on an idle cycle");
  // column cycles repeat the transfer flag shown at the activate
  a_col_flag: assert property (@(posedge clk) disable iff (srst)
    (rd_ff || wr_ff) |-> addr_ff[SRM_XFER_BIT] == chk_act_lines[16])
    else $error("transfer flag on column differs from activate");

endmodule // srm_addr_mux

// ===== testbench/srm_sdram_model.sv
// srm_sdram_model: behavioural sdram that captures the address lines on each command.
// assumes the mux raises at most one strobe per cycle, launched on the rising edge.
`timescale 1ns/1ps
module srm_sdram_model (
  input wire logic clk,
  input wire logic [19:0] ext_addr_pin,
  input wire logic row_activate_cmd,
  input wire logic column_write_cmd,
  input wire logic column_read_cmd,
  output logic [19:0] open_row_ff, // word seen at the last activate
  output logic [19:0] last_col_ff // word seen at the last read or write
);
  // capture on the edge after the strobe rises, as the memory itself does
  always_ff @(posedge clk) begin
    if (row_activate_cmd) begin
      open_row_ff <= ext_addr_pin;
    end
    if (column_write_cmd || column_read_cmd) begin
      last_col_ff <= ext_addr_pin;
    end
  end
endmodule // srm_sdram_model

// ===== testbench/sdram_row_column_address_mux_tb_top.sv
// sdram_row_column_address_mux_tb_top: directed bench for the address mux.
// assumes inputs change at the falling edge and outputs settle after the rising edge.
`timescale 1ns/1ps
module sdram_row_column_address_mux_tb_top;
  import srm_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [1:0] cmd = 2'h0, col_cfg = 2'h0, width_cfg = 2'h0;
  logic [28:0] byte_addr = 29'h0;
  logic xfer_normal = 1'b1;
  logic [4:0] row_bank_bits = 5'h0d;
  logic [19:0] ext_addr_pin, open_row, last_col, exp_row;
  logic row_activate_cmd, column_write_cmd, column_read_cmd;
  int err_total = 0, num_checks = 0;
  always #10 clk = ~clk; // 50 MHz
  srm_addr_mux dut_u (.clk(clk), .srst(srst), .cmd(cmd), .byte_addr(byte_addr),
    .xfer_normal(xfer_normal), .col_cfg(col_cfg), .width_cfg(width_cfg),
    .row_bank_bits(row_bank_bits), .ext_addr_pin(ext_addr_pin),
    .row_activate_cmd(row_activate_cmd), .column_write_cmd(column_write_cmd),
    .column_read_cmd(column_read_cmd));
  srm_sdram_model mem_u (.clk(clk), .ext_addr_pin(ext_addr_pin),
    .row_activate_cmd(row_activate_cmd), .column_write_cmd(column_write_cmd),
    .column_read_cmd(column_read_cmd), .open_row_ff(open_row), .last_col_ff(last_col));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_word(input logic [19:0] got, input logic [19:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_strobe(input logic [2:0] got, input logic [2:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // expected pin word worked out from geometry; column lines come from the lsb
  function automatic logic [19:0] exp_word(input logic col, input logic [28:0] a,
    input logic x);
    logic [19:0] r;
    int n;
    r = 20'h00000;
    n = 8 + col_cfg;
    for (int k = 0; k < 16; k++) begin
      if (!col && k < row_bank_bits) r[k] = a[n + width_cfg + k];
      if (col && k < n) r[k] = a[width_cfg + k];
    end
    if (col) r[15:10] = {exp_row[15:11], 1'b0};
    r[16] = x;
    return r;
  endfunction
  // present one command at a falling edge, judge the pins one cycle later
  task automatic issue(input logic [1:0] c, input logic [28:0] a, input logic x,
    input logic [19:0] e, input logic [2:0] s);
    cmd = c;
    byte_addr = a;
    xfer_normal = x;
    @(negedge clk);
    chk_word(ext_addr_pin, e);
    chk_strobe({row_activate_cmd, column_write_cmd, column_read_cmd}, s);
  endtask
  // activate, then back-to-back read and write; write address differs from byte bit 11 up
  task automatic run_access(input logic [28:0] a, input logic x);
    logic [28:0] b;
    b = a ^ 29'h1ffff800;
    exp_row = exp_word(1'b0, a, x);
    issue(SRM_CMD_ACT, a, x, exp_row, 3'h4);
    issue(SRM_CMD_RD, a, ~x, exp_word(1'b1, a, x), 3'h1);
    issue(SRM_CMD_WR, b, ~x, exp_word(1'b1, b, x), 3'h2);
    cmd = SRM_CMD_IDLE;
    @(negedge clk);
    chk_word(20'(last_col[15:11]), 20'(open_row[15:11]));
    chk_word(open_row, exp_row);
    chk_word(ext_addr_pin, exp_word(1'b1, b, x));
    chk_strobe({row_activate_cmd, column_write_cmd, column_read_cmd}, 3'h0);
  endtask
  // reset in mid-run, then a read with no activate: bank copy 0, flag copy at reset value
  task automatic t_mid_reset();
    srst = 1'b1;
    repeat (2) @(negedge clk);
    srst = 1'b0;
    chk_word(ext_addr_pin, SRM_ADDR_RST);
    chk_strobe({row_activate_cmd, column_write_cmd, column_read_cmd}, 3'h0);
    @(negedge clk);
    exp_row = 20'h00000;
    issue(SRM_CMD_RD, 29'h15555555, 1'b0,
      exp_word(1'b1, 29'h15555555, SRM_XFER_RST), 3'h1);
    cmd = SRM_CMD_IDLE;
    @(negedge clk);
  endtask
  // every column count with every bus width
  task automatic t_geometry();
    for (int c = 0; c < 3; c++) begin
      for (int w = 0; w < 4; w++) begin
        col_cfg = c[1:0];
        width_cfg = w[1:0];
        run_access(29'h1a5c3e97 + 29'(c * 4 + w), 1'b1);
      end
    end
  endtask
  // direct transfer flag low, then ordinary flag high on the next row
  task automatic t_xfer_flag();
    col_cfg = 2'h1;
    width_cfg = 2'h2;
    run_access(29'h0f0f0f0f, 1'b0);
    run_access(29'h10f0f0f1, 1'b1);
  endtask
  // all-ones address: lines past the geometry must stay low at both ends of the range
  task automatic t_high_lines();
    col_cfg = 2'h2;
    width_cfg = 2'h3;
    row_bank_bits = 5'h10;
    run_access(29'h1fffffff, 1'b1);
    col_cfg = 2'h0;
    width_cfg = 2'h0;
    row_bank_bits = 5'h04;
    run_access(29'h1fffffff, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(negedge clk);
    chk_word(ext_addr_pin, SRM_ADDR_RST);
    srst = 1'b0;
    @(negedge clk);
    t_geometry();
    t_xfer_flag();
    t_mid_reset();
    t_high_lines();
    give_verdict();
  end
  // the whole sequence needs well under 200 cycles; cut a hang short
  initial begin
    #(20 * 2000);
    err_total++;
    give_verdict();
  end
endmodule // sdram_row_column_address_mux_tb_top
